// File: logic/pbc_consts.svh
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

// Register byte offsets
`define PBC_OFF_BLANK_CTRL   6'h00
`define PBC_OFF_BLANK_DELAY  6'h04
`define PBC_OFF_AUX_CTRL     6'h08
`define PBC_OFF_GEN_CTRL     6'h0c
`define PBC_OFF_PRESCALE     6'h10
`define PBC_OFF_CARRIER      6'h14
`define PBC_OFF_CAPTURE      6'h18
`define PBC_OFF_DEADTIME     6'h1c
`define PBC_OFF_ALT_DEADTIME 6'h20
`define PBC_OFF_DUTY         6'h24
`define PBC_OFF_ADJ_DUTY     6'h28
`define PBC_OFF_STATUS       6'h2c

// Blanking control fields
`define PBC_BC_HIGH_RISE     15
`define PBC_BC_HIGH_FALL     14
`define PBC_BC_LOW_RISE      13
`define PBC_BC_LOW_FALL      12
`define PBC_BC_FAULT_EN      11
`define PBC_BC_CL_EN         10
`define PBC_BC_DUR_V1_HI     9
`define PBC_BC_DUR_V1_LO     3
`define PBC_BC_CARRIER_HIGH  5
`define PBC_BC_CARRIER_LOW   4
`define PBC_BC_HOUT_HIGH     3
`define PBC_BC_HOUT_LOW      2
`define PBC_BC_LOUT_HIGH     1
`define PBC_BC_LOUT_LOW      0
`define PBC_BD_DUR_V2_HI     11
`define PBC_BD_DUR_V2_LO     3

// Auxiliary control fields
`define PBC_AUX_BLANK_SEL_HI 11
`define PBC_AUX_BLANK_SEL_LO 8
`define PBC_AUX_CAR_SEL_HI   5
`define PBC_AUX_CAR_SEL_LO   2
`define PBC_AUX_GATE_HIGH    1
`define PBC_AUX_GATE_LOW     0

// Generator control, prescale and carrier fields
`define PBC_GC_COMP_HI       7
`define PBC_GC_COMP_LO       6
`define PBC_PS_DIV_HI        2
`define PBC_CAR_ENABLE       15
`define PBC_CAR_RATIO_HI     9

`define PBC_RESET_VALUE      16'h0000

// Timing
`define PBC_CLK_PERIOD_PS    5000
`define PBC_BLANK_STEP_PS    8320
`define PBC_BLANK_MAX_NS     4252
`define PBC_BLANK_STEP_CYC   ((`PBC_BLANK_STEP_PS + `PBC_CLK_PERIOD_PS - 1) / `PBC_CLK_PERIOD_PS)

`endif

// File: logic/pbc_pkg.sv
package pbc_pkg;

  typedef enum logic [1:0] {
    PBC_BUS_IDLE = 2'b00,
    PBC_BUS_ACK  = 2'b01
  } pbc_bus_e;

  typedef struct packed {
    logic [15:0] blank_ctrl;
    logic [15:0] blank_delay;
    logic [15:0] aux_ctrl;
    logic [15:0] gen_ctrl;
    logic [15:0] prescale;
    logic [15:0] carrier_ctrl;
    logic [15:0] deadtime;
    logic [15:0] alt_deadtime;
    logic [15:0] duty;
    logic [15:0] capture;
    logic [15:0] adj_duty;
    logic [15:0] dt_high;
    logic [15:0] dt_low;
    logic [8:0]  blank_timer;
    logic [9:0]  pre_cnt;
    logic [9:0]  car_cnt;
    logic        carrier;
    logic        hi_prev;
    logic        lo_prev;
    logic        flt_s1;
    logic        flt_s2;
    logic        cl_s1;
    logic        cl_s2;
    logic        cmp_s1;
    logic        cmp_s2;
    logic        fault_q;
    logic        cl_q;
    logic        high_out;
    logic        low_out;
    pbc_bus_e    bus;
    logic [31:0] rdata;
  } pbc_state_s;

endpackage

// File: logic/pbc_top.sv
`include "pbc_consts.svh"

// Operation
// - Blank fault and limit for programmed interval
// - Duration field: v1 control, v2 delay register
// - Four edge selects start the blanking timer
// - New selected edge restarts running timer
// - Edges taken before output polarity inversion
// - Edges taken after dead-time insertion
// - Separate blanking enables for fault, limit
// - Version two: state blanking on conditions
// - Source select picks state-blanking generator
// - Limit rising edge captures time base
// - Only blanked limit signal triggers capture
// - Secondary time base never captured
// - Compensation input adds or subtracts deadtime
// - Alternate deadtime always used for low output, for high output only with compensation
// - Output gated by AND with carrier
// - Carrier divides prescaled clock when enabled
// - Per-output gating enables, else unchanged
// - Carrier source: own generator or others
// - Gating applied after override processing
// - Carrier clock driven out of module
module pbc_top
  import pbc_pkg::*;
#(
  parameter int VERSION = 2,
  parameter int NGEN    = 16
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [5:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic              pwm_high_in,
  input  wire logic              pwm_low_in,
  input  wire logic              override_high_in,
  input  wire logic              override_low_in,
  input  wire logic [NGEN-1:0]   gen_high_bus,
  input  wire logic [NGEN-1:0]   gen_low_bus,
  input  wire logic [15:0]       itb_count,
  input  wire logic              fault_pin,
  input  wire logic              current_limit_pin,
  input  wire logic              deadtime_comp_input,
  output logic                   fault_blanked,
  output logic                   current_limit_blanked,
  output logic                   high_side_output,
  output logic                   low_side_output,
  output logic                   carrier_clock_out,
  output logic      [15:0]       adjusted_duty_out,
  output logic      [15:0]       deadtime_high_out,
  output logic      [15:0]       deadtime_low_out
);

  pbc_state_s st_ff;
  pbc_state_s nxt_st;

  function automatic logic pick(input logic [NGEN-1:0] bus, input logic [3:0] idx);
    pick = bus[idx];
  endfunction

  function automatic logic [31:0] rd(input pbc_state_s s, input logic [5:0] a, input logic [3:0] stat);
    case (a)
      `PBC_OFF_BLANK_CTRL:   rd = {16'h0000, s.blank_ctrl};
      `PBC_OFF_BLANK_DELAY:  rd = {16'h0000, s.blank_delay};
      `PBC_OFF_AUX_CTRL:     rd = {16'h0000, s.aux_ctrl};
      `PBC_OFF_GEN_CTRL:     rd = {16'h0000, s.gen_ctrl};
      `PBC_OFF_PRESCALE:     rd = {16'h0000, s.prescale};
      `PBC_OFF_CARRIER:      rd = {16'h0000, s.carrier_ctrl};
      `PBC_OFF_CAPTURE:      rd = {16'h0000, s.capture};
      `PBC_OFF_DEADTIME:     rd = {16'h0000, s.deadtime};
      `PBC_OFF_ALT_DEADTIME: rd = {16'h0000, s.alt_deadtime};
      `PBC_OFF_DUTY:         rd = {16'h0000, s.duty};
      `PBC_OFF_ADJ_DUTY:     rd = {16'h0000, s.adj_duty};
      `PBC_OFF_STATUS:       rd = {28'h0000000, stat};
      default:               rd = 32'h00000000;
    endcase
  endfunction

  logic [8:0]  blank_dur;
  logic        trig_edge;
  logic        tick;
  logic [9:0]  tick_limit;
  logic        edge_blank;
  logic        state_blank;
  logic        blank;
  logic        carrier_sel;
  logic        state_high;
  logic        state_low;
  logic        fault_now;
  logic        cl_now;
  logic        comp_on;
  logic [9:0]  car_ratio;
  logic        car_en;
  logic [3:0]  status;

  always_comb begin
    blank_dur  = (VERSION == 2) ? st_ff.blank_delay[`PBC_BD_DUR_V2_HI:`PBC_BD_DUR_V2_LO]
                                : {2'b00, st_ff.blank_ctrl[`PBC_BC_DUR_V1_HI:`PBC_BC_DUR_V1_LO]};
    // Inputs are pre-polarity, post-deadtime drive signals
    trig_edge  = (st_ff.blank_ctrl[`PBC_BC_HIGH_RISE] & pwm_high_in & ~st_ff.hi_prev)
               | (st_ff.blank_ctrl[`PBC_BC_HIGH_FALL] & ~pwm_high_in & st_ff.hi_prev)
               | (st_ff.blank_ctrl[`PBC_BC_LOW_RISE] & pwm_low_in & ~st_ff.lo_prev)
               | (st_ff.blank_ctrl[`PBC_BC_LOW_FALL] & ~pwm_low_in & st_ff.lo_prev);
    // Step never shorter than the nominal 8.32 ns, scaled by prescale
    tick_limit = 10'((`PBC_BLANK_STEP_CYC) << st_ff.prescale[`PBC_PS_DIV_HI:0]);
    tick       = (st_ff.pre_cnt >= tick_limit - 10'd1);
    edge_blank = (st_ff.blank_timer != 9'd0);
    car_ratio  = st_ff.carrier_ctrl[`PBC_CAR_RATIO_HI:0];
    car_en     = st_ff.carrier_ctrl[`PBC_CAR_ENABLE];
    carrier_sel = (st_ff.aux_ctrl[`PBC_AUX_CAR_SEL_HI:`PBC_AUX_CAR_SEL_LO] == 4'h0) ? st_ff.carrier
                : pick(gen_high_bus, st_ff.aux_ctrl[`PBC_AUX_CAR_SEL_HI:`PBC_AUX_CAR_SEL_LO]);
    state_high = pick(gen_high_bus, st_ff.aux_ctrl[`PBC_AUX_BLANK_SEL_HI:`PBC_AUX_BLANK_SEL_LO]);
    state_low  = pick(gen_low_bus, st_ff.aux_ctrl[`PBC_AUX_BLANK_SEL_HI:`PBC_AUX_BLANK_SEL_LO]);
    state_blank = (VERSION == 2) &&
                  ((st_ff.blank_ctrl[`PBC_BC_CARRIER_HIGH] & carrier_sel)
                 | (st_ff.blank_ctrl[`PBC_BC_CARRIER_LOW] & ~carrier_sel)
                 | (st_ff.blank_ctrl[`PBC_BC_HOUT_HIGH] & state_high)
                 | (st_ff.blank_ctrl[`PBC_BC_HOUT_LOW] & ~state_high)
                 | (st_ff.blank_ctrl[`PBC_BC_LOUT_HIGH] & state_low)
                 | (st_ff.blank_ctrl[`PBC_BC_LOUT_LOW] & ~state_low));
    blank      = edge_blank | state_blank;
    fault_now  = st_ff.flt_s2 & ~(st_ff.blank_ctrl[`PBC_BC_FAULT_EN] & blank);
    cl_now     = st_ff.cl_s2 & ~(st_ff.blank_ctrl[`PBC_BC_CL_EN] & blank);
    comp_on    = (st_ff.gen_ctrl[`PBC_GC_COMP_HI:`PBC_GC_COMP_LO] != 2'b00);
    status     = {st_ff.fault_q, st_ff.cl_q, blank, carrier_sel};
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.hi_prev = pwm_high_in;
    nxt_st.lo_prev = pwm_low_in;
    nxt_st.flt_s1  = fault_pin;
    nxt_st.flt_s2  = st_ff.flt_s1;
    nxt_st.cl_s1   = current_limit_pin;
    nxt_st.cl_s2   = st_ff.cl_s1;
    nxt_st.cmp_s1  = deadtime_comp_input;
    nxt_st.cmp_s2  = st_ff.cmp_s1;
    nxt_st.pre_cnt = tick ? 10'd0 : st_ff.pre_cnt + 10'd1;

    if (trig_edge) begin
      nxt_st.blank_timer = blank_dur;
    end else if (tick && edge_blank) begin
      nxt_st.blank_timer = st_ff.blank_timer - 9'd1;
    end

    nxt_st.fault_q = fault_now;
    nxt_st.cl_q    = cl_now;
    // Only the primary time base is captured; overwritten by the next edge
    if (cl_now && !st_ff.cl_q) begin
      nxt_st.capture = itb_count;
    end

    // Ratio of zero parks the carrier low instead of running at full rate
    if (!car_en || car_ratio == 10'd0) begin
      nxt_st.car_cnt = 10'd0;
      nxt_st.carrier = 1'b0;
    end else if (tick) begin
      if (st_ff.car_cnt >= car_ratio - 10'd1) begin
        nxt_st.car_cnt = 10'd0;
        nxt_st.carrier = ~st_ff.carrier;
      end else begin
        nxt_st.car_cnt = st_ff.car_cnt + 10'd1;
      end
    end

    // Override inputs already carry limit and fault processing
    nxt_st.high_out = override_high_in & (~st_ff.aux_ctrl[`PBC_AUX_GATE_HIGH] | carrier_sel);
    nxt_st.low_out  = override_low_in & (~st_ff.aux_ctrl[`PBC_AUX_GATE_LOW] | carrier_sel);

    // No saturation: software keeps duty and deadtime in range
    if (!comp_on) begin
      nxt_st.adj_duty = st_ff.duty;
    end else if (st_ff.cmp_s2) begin
      nxt_st.adj_duty = st_ff.duty + st_ff.deadtime;
    end else begin
      nxt_st.adj_duty = st_ff.duty - st_ff.deadtime;
    end
    nxt_st.dt_high = comp_on ? st_ff.alt_deadtime : st_ff.deadtime;
    nxt_st.dt_low  = st_ff.alt_deadtime;

    case (st_ff.bus)
      PBC_BUS_IDLE: begin
        if (read || write) begin
          nxt_st.bus   = PBC_BUS_ACK;
          nxt_st.rdata = read ? rd(st_ff, address, status) : 32'h00000000;
        end
      end
      PBC_BUS_ACK: begin
        nxt_st.bus = PBC_BUS_IDLE;
        if (write) begin
          case (address)
            `PBC_OFF_BLANK_CTRL:   nxt_st.blank_ctrl = writedata[15:0];
            `PBC_OFF_BLANK_DELAY:  nxt_st.blank_delay = writedata[15:0];
            `PBC_OFF_AUX_CTRL:     nxt_st.aux_ctrl = writedata[15:0];
            `PBC_OFF_GEN_CTRL:     nxt_st.gen_ctrl = writedata[15:0];
            `PBC_OFF_PRESCALE:     nxt_st.prescale = writedata[15:0];
            `PBC_OFF_CARRIER:      nxt_st.carrier_ctrl = writedata[15:0];
            `PBC_OFF_DEADTIME:     nxt_st.deadtime = writedata[15:0];
            `PBC_OFF_ALT_DEADTIME: nxt_st.alt_deadtime = writedata[15:0];
            `PBC_OFF_DUTY:         nxt_st.duty = writedata[15:0];
            default: ;
          endcase
        end
      end
      default: nxt_st.bus = PBC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign waitrequest           = (st_ff.bus != PBC_BUS_ACK);
  assign readdata              = st_ff.rdata;
  assign fault_blanked         = st_ff.fault_q;
  assign current_limit_blanked = st_ff.cl_q;
  assign high_side_output      = st_ff.high_out;
  assign low_side_output       = st_ff.low_out;
  assign carrier_clock_out     = st_ff.carrier;
  assign adjusted_duty_out     = st_ff.adj_duty;
  assign deadtime_high_out     = st_ff.dt_high;
  assign deadtime_low_out      = st_ff.dt_low;

  sequence s_edge_seen;
    trig_edge;
  endsequence

  sequence s_timer_loaded;
    ##1 (st_ff.blank_timer == $past(blank_dur));
  endsequence

  a_edge_loads_timer: assert property (@(posedge clk) disable iff (!resetn)
    s_edge_seen |-> s_timer_loaded) else $error("blanking timer not reloaded on edge");

  a_zero_no_blank: assert property (@(posedge clk) disable iff (!resetn)
    (blank_dur == 9'd0 && !edge_blank) |=> !edge_blank) else $error("blanking with zero duration");

  a_timer_step: assert property (@(posedge clk) disable iff (!resetn)
    (!trig_edge && tick && edge_blank) |=> st_ff.blank_timer == $past(st_ff.blank_timer) - 9'd1)
    else $error("blanking timer did not step");

  a_fault_masked: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff.blank_ctrl[`PBC_BC_FAULT_EN] && edge_blank) |=> !fault_blanked)
    else $error("fault passed during blanking");

  a_limit_passes: assert property (@(posedge clk) disable iff (!resetn)
    (!st_ff.blank_ctrl[`PBC_BC_CL_EN]) |=> current_limit_blanked == $past(st_ff.cl_s2))
    else $error("unblanked limit altered");

  a_capture_edge: assert property (@(posedge clk) disable iff (!resetn)
    (cl_now && !st_ff.cl_q) |=> st_ff.capture == $past(itb_count)) else $error("capture missed");

  a_capture_hold: assert property (@(posedge clk) disable iff (!resetn)
    !(cl_now && !st_ff.cl_q) |=> $stable(st_ff.capture)) else $error("capture without edge");

  a_gate_high: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> high_side_output == $past(override_high_in & (~st_ff.aux_ctrl[`PBC_AUX_GATE_HIGH] | carrier_sel)))
    else $error("high output gating wrong");

  a_carrier_toggle: assert property (@(posedge clk) disable iff (!resetn)
    (car_en && car_ratio != 10'd0 && !(tick && st_ff.car_cnt >= car_ratio - 10'd1)) |=> $stable(st_ff.carrier))
    else $error("carrier changed early");

  a_comp_add: assert property (@(posedge clk) disable iff (!resetn)
    (comp_on && st_ff.cmp_s2) |=> adjusted_duty_out == $past(st_ff.duty + st_ff.deadtime))
    else $error("compensated duty wrong");

  a_comp_sub: assert property (@(posedge clk) disable iff (!resetn)
    (comp_on && !st_ff.cmp_s2) |=> adjusted_duty_out == $past(st_ff.duty - st_ff.deadtime))
    else $error("compensated duty not reduced");

  a_comp_bypass: assert property (@(posedge clk) disable iff (!resetn)
    !comp_on |=> adjusted_duty_out == $past(st_ff.duty))
    else $error("duty altered without compensation");

  a_alt_both: assert property (@(posedge clk) disable iff (!resetn)
    comp_on |=> (deadtime_high_out == $past(st_ff.alt_deadtime))
                && (deadtime_low_out == $past(st_ff.alt_deadtime)))
    else $error("alternate deadtime not applied");

  a_chop_low: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff.aux_ctrl[`PBC_AUX_GATE_LOW] && !carrier_sel) |=> !low_side_output)
    else $error("low output not chopped");

  a_low_unchopped: assert property (@(posedge clk) disable iff (!resetn)
    !st_ff.aux_ctrl[`PBC_AUX_GATE_LOW] |=> low_side_output == $past(override_low_in))
    else $error("unchopped low output altered");

  a_limit_masked: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff.blank_ctrl[`PBC_BC_CL_EN] && blank) |=> !current_limit_blanked)
    else $error("limit passed during blanking");

  a_fault_passes: assert property (@(posedge clk) disable iff (!resetn)
    !st_ff.blank_ctrl[`PBC_BC_FAULT_EN] |=> fault_blanked == $past(st_ff.flt_s2))
    else $error("unblanked fault altered");

  a_state_high_blank: assert property (@(posedge clk) disable iff (!resetn)
    (VERSION == 2 && st_ff.blank_ctrl[`PBC_BC_FAULT_EN] && st_ff.blank_ctrl[`PBC_BC_HOUT_HIGH]
     && gen_high_bus[st_ff.aux_ctrl[`PBC_AUX_BLANK_SEL_HI:`PBC_AUX_BLANK_SEL_LO]]) |=> !fault_blanked)
    else $error("state blanking missed");

  a_carrier_idle: assert property (@(posedge clk) disable iff (!resetn)
    !car_en |=> !carrier_clock_out)
    else $error("carrier ran while disabled");

  a_carrier_flip: assert property (@(posedge clk) disable iff (!resetn)
    (car_en && car_ratio != 10'd0 && tick && st_ff.car_cnt >= car_ratio - 10'd1)
    |=> carrier_clock_out != $past(carrier_clock_out))
    else $error("carrier missed its toggle");

  a_timer_hold: assert property (@(posedge clk) disable iff (!resetn)
    (!trig_edge && !(tick && edge_blank)) |=> $stable(st_ff.blank_timer))
    else $error("blanking timer moved without cause");

  a_high_rise_trig: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff.blank_ctrl[`PBC_BC_HIGH_RISE] && pwm_high_in && !st_ff.hi_prev)
    |=> st_ff.blank_timer == $past(blank_dur))
    else $error("high rising edge did not start blanking");

  a_low_fall_trig: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff.blank_ctrl[`PBC_BC_LOW_FALL] && !pwm_low_in && st_ff.lo_prev)
    |=> st_ff.blank_timer == $past(blank_dur))
    else $error("low falling edge did not start blanking");

  a_capture_blanked: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff.blank_ctrl[`PBC_BC_CL_EN] && blank) |=> $stable(st_ff.capture))
    else $error("capture inside blanking");

  a_bus_one_wait: assert property (@(posedge clk) disable iff (!resetn)
    !waitrequest |=> waitrequest)
    else $error("bus acknowledge held too long");

  a_duty_write: assert property (@(posedge clk) disable iff (!resetn)
    (!waitrequest && write && address == `PBC_OFF_DUTY) |=> st_ff.duty == $past(writedata[15:0]))
    else $error("register write lost");

endmodule

// File: verification/pbc_stage_model.sv
// Gate driver plus current-sense comparator seen by one generator
module pbc_stage_model #(
  parameter int TRIP = 4
) (
  input  wire logic clk,
  input  wire logic high_side_output,
  input  wire logic trip_en,
  input  wire logic fault_req,
  input  wire logic comp_req,
  output logic      fault_pin = 1'b0,
  output logic      current_limit_pin = 1'b0,
  output logic      deadtime_comp_input = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  int ramp = 0;
  // Inductor current ramps while the high switch conducts; resets when it opens
  always @(posedge clk) begin
    ramp <= high_side_output ? ramp + 1 : 0;
    current_limit_pin <= trip_en && high_side_output && ramp >= TRIP;
    fault_pin <= fault_req;
    deadtime_comp_input <= comp_req;
  end
endmodule

// File: verification/tb.sv
`include "pbc_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, resetn = 0, read = 0, write = 0, waitrequest;
  logic [5:0] address = 0;
  logic [31:0] writedata = 0, readdata;
  logic pwm_high_in = 0, pwm_low_in = 0, override_high_in = 0, override_low_in = 0;
  logic [15:0] gen_high_bus = 0, gen_low_bus = 0, itb_count = 0;
  logic fault_pin, current_limit_pin, deadtime_comp_input, trip_en = 0, fault_req = 0, comp_req = 0;
  logic fault_blanked, current_limit_blanked, high_side_output, low_side_output, carrier_clock_out;
  logic [15:0] adjusted_duty_out, deadtime_high_out, deadtime_low_out;
  int error_cnt = 0, check_count = 0;

  pbc_top pbc_top_i (.clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pwm_high_in(pwm_high_in),
    .pwm_low_in(pwm_low_in), .override_high_in(override_high_in), .override_low_in(override_low_in),
    .gen_high_bus(gen_high_bus), .gen_low_bus(gen_low_bus), .itb_count(itb_count), .fault_pin(fault_pin),
    .current_limit_pin(current_limit_pin), .deadtime_comp_input(deadtime_comp_input),
    .fault_blanked(fault_blanked), .current_limit_blanked(current_limit_blanked),
    .high_side_output(high_side_output), .low_side_output(low_side_output),
    .carrier_clock_out(carrier_clock_out), .adjusted_duty_out(adjusted_duty_out),
    .deadtime_high_out(deadtime_high_out), .deadtime_low_out(deadtime_low_out));
  pbc_stage_model pbc_stage_model_i (.clk(clk), .high_side_output(high_side_output), .trip_en(trip_en),
    .fault_req(fault_req), .comp_req(comp_req), .fault_pin(fault_pin),
    .current_limit_pin(current_limit_pin), .deadtime_comp_input(deadtime_comp_input));

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) itb_count <= itb_count + 16'h0001;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until waitrequest is seen low, then released and one edge let pass
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    if (n >= 64) check("bus_timeout", 0, 1);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, a, {16'h0000, d}, x);
  endtask
  task automatic rdc(input string name, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(name, x, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic blank_run(input logic on_low, input logic val, input logic lim, output int n);
    n = 0;
    if (on_low) pwm_low_in <= val;
    else pwm_high_in <= val;
    repeat (60) begin
      @(posedge clk);
      if ((lim ? current_limit_blanked : fault_blanked) === 1'b0) n++;
    end
  endtask
  task automatic half_len(output int n);
    int k;
    n = 0;
    k = 0;
    while (carrier_clock_out !== 1'b0 && k < 300) begin @(posedge clk); k++; end
    while (carrier_clock_out !== 1'b1 && k < 300) begin @(posedge clk); k++; end
    while (carrier_clock_out === 1'b1 && k < 300) begin @(posedge clk); k++; n++; end
  endtask

  task automatic t_regs();
    rdc("ctrl_rst", `PBC_OFF_BLANK_CTRL, 0);
    rdc("aux_rst", `PBC_OFF_AUX_CTRL, 0);
    wr(`PBC_OFF_BLANK_CTRL, 16'hcc3f);
    rdc("ctrl_rw", `PBC_OFF_BLANK_CTRL, 32'h0000cc3f);
    wr(`PBC_OFF_CAPTURE, 16'hbeef);
    rdc("capture_ro", `PBC_OFF_CAPTURE, 0);
    wr(6'h3c, 16'h1234);
    rdc("unmapped", 6'h3c, 0);
    wr(`PBC_OFF_BLANK_CTRL, 16'h0000);
  endtask

  task automatic t_comp();
    wr(`PBC_OFF_DEADTIME, 16'h000a);
    wr(`PBC_OFF_ALT_DEADTIME, 16'h0003);
    wr(`PBC_OFF_DUTY, 16'h0064);
    comp_req <= 1'b1;
    cyc(6);
    check("dt_high_off", deadtime_high_out, 16'h000a);
    for (int m = 1; m < 4; m++) begin
      wr(`PBC_OFF_GEN_CTRL, 16'(m << 6));
      cyc(2);
      check("duty_add", adjusted_duty_out, 16'h006e);
      check("dt_high_on", deadtime_high_out, 16'h0003);
      check("dt_low_on", deadtime_low_out, 16'h0003);
    end
    rdc("adj_reg", `PBC_OFF_ADJ_DUTY, 32'h0000006e);
    comp_req <= 1'b0;
    cyc(6);
    check("duty_sub", adjusted_duty_out, 16'h005a);
    wr(`PBC_OFF_GEN_CTRL, 16'h0000);
  endtask

  task automatic t_carrier();
    int n;
    wr(`PBC_OFF_CARRIER, 16'h0003);
    cyc(4);
    half_len(n);
    check("carrier_off", n, 0);
    wr(`PBC_OFF_CARRIER, 16'h8003);
    half_len(n);
    check("half_ps0", n, 6);
    wr(`PBC_OFF_PRESCALE, 16'h0001);
    half_len(n);
    check("half_ps1", n, 12);
    wr(`PBC_OFF_PRESCALE, 16'h0000);
  endtask

  task automatic t_gate();
    logic e;
    override_low_in <= 1'b1;
    override_high_in <= 1'b1;
    wr(`PBC_OFF_AUX_CTRL, 16'h0001);
    e = carrier_clock_out;
    repeat (30) begin
      @(posedge clk);
      check("low_gated", low_side_output, e);
      check("high_plain", high_side_output, 1);
      e = carrier_clock_out;
    end
    wr(`PBC_OFF_AUX_CTRL, 16'h000e);
    e = override_high_in & gen_high_bus[3];
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      check("high_by_gen", high_side_output, e);
      check("low_plain", low_side_output, 1);
      e = override_high_in & gen_high_bus[3];
      gen_high_bus[3] <= k[1];
      override_high_in <= !k[2];
    end
    override_high_in <= 1'b0;
    wr(`PBC_OFF_AUX_CTRL, 16'h0000);
  endtask

  task automatic t_edges();
    int n;
    fault_req <= 1'b1;
    wr(`PBC_OFF_BLANK_DELAY, 16'h0028);
    for (int i = 0; i < 4; i++) begin
      wr(`PBC_OFF_BLANK_CTRL, (16'h8000 >> i) | 16'h0800);
      if (i > 1) pwm_low_in <= i[0];
      else pwm_high_in <= i[0];
      cyc(4);
      check("unselected", fault_blanked, 1);
      blank_run(i[1], !i[0], 1'b0, n);
      check("blank_len", n >= 9 && n <= 12, 1);
    end
    wr(`PBC_OFF_BLANK_CTRL, 16'hc800);
    pwm_high_in <= 1'b1;
    cyc(5);
    blank_run(1'b0, 1'b0, 1'b0, n);
    check("restart_len", n >= 9 && n <= 12, 1);
    wr(`PBC_OFF_BLANK_CTRL, 16'h8000);
    blank_run(1'b0, 1'b1, 1'b0, n);
    check("no_enable", n, 0);
    wr(`PBC_OFF_BLANK_CTRL, 16'h8800);
    wr(`PBC_OFF_BLANK_DELAY, 16'h0000);
    pwm_high_in <= 1'b0;
    cyc(2);
    blank_run(1'b0, 1'b1, 1'b0, n);
    check("zero_len", n, 0);
    pwm_high_in <= 1'b0;
  endtask

  task automatic t_state();
    wr(`PBC_OFF_BLANK_CTRL, 16'h0808);
    wr(`PBC_OFF_AUX_CTRL, 16'h0200);
    gen_high_bus[2] <= 1'b1;
    cyc(5);
    check("state_hi", fault_blanked, 0);
    gen_high_bus[2] <= 1'b0;
    cyc(5);
    check("state_lo", fault_blanked, 1);
    wr(`PBC_OFF_BLANK_CTRL, 16'h0801);
    cyc(5);
    check("state_low_out", fault_blanked, 0);
    wr(`PBC_OFF_AUX_CTRL, 16'h020c);
    gen_high_bus[3] <= 1'b1;
    wr(`PBC_OFF_BLANK_CTRL, 16'h0820);
    cyc(5);
    check("state_car_hi", fault_blanked, 0);
    wr(`PBC_OFF_BLANK_CTRL, 16'h0810);
    cyc(5);
    check("state_car_lo", fault_blanked, 1);
    wr(`PBC_OFF_BLANK_CTRL, 16'h0000);
    wr(`PBC_OFF_AUX_CTRL, 16'h0000);
    fault_req <= 1'b0;
  endtask

  task automatic t_capture();
    logic [31:0] x;
    logic [15:0] v;
    int k;
    trip_en <= 1'b1;
    wr(`PBC_OFF_BLANK_DELAY, 16'h00a0);
    wr(`PBC_OFF_BLANK_CTRL, 16'h8400);
    pwm_high_in <= 1'b1;
    override_high_in <= 1'b1;
    cyc(10);
    override_high_in <= 1'b0;
    rdc("capture_blanked", `PBC_OFF_CAPTURE, 0);
    pwm_high_in <= 1'b0;
    cyc(50);
    wr(`PBC_OFF_BLANK_DELAY, 16'h0000);
    override_high_in <= 1'b1;
    k = 0;
    while (current_limit_pin !== 1'b1 && k < 50) begin @(posedge clk); k++; end
    v = itb_count;
    cyc(8);
    bus(1'b0, `PBC_OFF_CAPTURE, 32'h0, x);
    check("capture_win", 16'(x[15:0] - v) <= 16'h0008, 1);
    wr(`PBC_OFF_BLANK_DELAY, 16'h0028);
    cyc(10);
    check("limit_pass", current_limit_blanked, 1);
    blank_run(1'b0, 1'b1, 1'b1, k);
    check("limit_len", k >= 9 && k <= 12, 1);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_comp();
    t_carrier();
    t_gate();
    t_edges();
    t_state();
    t_capture();
    stop_test();
  end
endmodule
